// file: dv/abd_line_model.sv
// abd_line_model.sv: remote sender of break and 0x55 sync on RXD
// assumes calls start just after a clock edge
`timescale 1ns/100ps
module abd_line_model (
  // clock
  input  wire  clk,
  // line, idles high
  output logic rxd
);
  initial rxd = 1'b1;
  task automatic hold(input logic v, input int n);
    rxd <= v;
    repeat (n) @(posedge clk);
  endtask
  task automatic send(input logic brk, input int bitc);
    logic [9:0] f;
    f = {1'b1, 8'h55, 1'b0};
    if (brk) begin
      hold(1'b0, 13 * bitc);
      hold(1'b1, bitc);
    end
    for (int i = 0; i < 10; i++)
      hold(f[i], bitc);
    hold(1'b1, bitc);
  endtask
endmodule

// file: dv/abd_properties.sv
// abd_properties.sv: port assertions for abd_top
// assumes one clock and a bind onto abd_top
`timescale 1ns/100ps
module abd_props (
  // clock and reset
  input wire        CLK_SYS,
  input wire        ARST_N,
  // interrupt
  input wire        IRQ,
  // write side
  input wire        S_AXI_AWVALID,
  input wire        S_AXI_AWREADY,
  input wire        S_AXI_WVALID,
  input wire        S_AXI_WREADY,
  input wire [1:0]  S_AXI_BRESP,
  input wire        S_AXI_BVALID,
  input wire        S_AXI_BREADY,
  // read side
  input wire [3:0]  S_AXI_ARADDR,
  input wire        S_AXI_ARVALID,
  input wire        S_AXI_ARREADY,
  input wire [31:0] S_AXI_RDATA,
  input wire        S_AXI_RVALID,
  input wire        S_AXI_RREADY
);
  logic [3:0] age_q;
  wire        rd_rx = S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == 4'hC;
  // cycles since a data read or a write; saturates, never wraps
  always @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N)
      age_q <= 4'hF;
    else if (rd_rx || (S_AXI_WVALID && S_AXI_WREADY))
      age_q <= 4'h0;
    else if (age_q != 4'hF)
      age_q <= age_q + 4'h1;
  end
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!ARST_N);
  a_b_follows: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |=> S_AXI_BVALID)
    else $error("write unanswered");
  a_b_holds: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write answer dropped");
  a_r_follows: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read unanswered");
  a_r_holds: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read answer dropped");
  a_ar_blocked: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read taken while busy");
  a_w_blocked: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
    else $error("write taken while busy");
  a_rdata_byte: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h0)
    else $error("upper read bits set");
  a_read_clears: assert property (rd_rx |-> ##2 !IRQ)
    else $error("interrupt kept after data read");
  a_irq_fall: assert property ($fell(IRQ) |-> age_q < 4'h4)
    else $error("interrupt dropped unprompted");
  c_write: cover property (S_AXI_BVALID && S_AXI_BREADY);
  c_irq: cover property ($rose(IRQ));
  c_rx_read: cover property (rd_rx);
endmodule
bind abd_top abd_props chk_u (
  .CLK_SYS       (CLK_SYS),
  .ARST_N        (ARST_N),
  .IRQ           (IRQ),
  .S_AXI_AWVALID (S_AXI_AWVALID),
  .S_AXI_AWREADY (S_AXI_AWREADY),
  .S_AXI_WVALID  (S_AXI_WVALID),
  .S_AXI_WREADY  (S_AXI_WREADY),
  .S_AXI_BRESP   (S_AXI_BRESP),
  .S_AXI_BVALID  (S_AXI_BVALID),
  .S_AXI_BREADY  (S_AXI_BREADY),
  .S_AXI_ARADDR  (S_AXI_ARADDR),
  .S_AXI_ARVALID (S_AXI_ARVALID),
  .S_AXI_ARREADY (S_AXI_ARREADY),
  .S_AXI_RDATA   (S_AXI_RDATA),
  .S_AXI_RVALID  (S_AXI_RVALID),
  .S_AXI_RREADY  (S_AXI_RREADY)
);

// file: dv/testbench.sv
// testbench.sv: register tests of abd_top with a serial sender
// assumes abd_top, abd_line_model and the checker compiled first
`timescale 1ns/100ps
`include "abd_defs.vh"
module testbench;
  logic        clk, arst_n, rxd, irq;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [3:0]  awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, d, c;
  logic [1:0]  bresp, rresp, r;
  int          err_count, cmp_count, pre;
  // irq mask, high speed, wide, wake
  logic [3:0]  tmode [6] = '{4'h8, 4'h4, 4'h2, 4'hE, 4'h4, 4'hF};
  int          tbit [6]  = '{256, 256, 256, 256, 4160, 256};
  abd_top dut_u (
    .CLK_SYS(clk), .ARST_N(arst_n), .RXD(rxd), .IRQ(irq),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready)
  );
  abd_line_model line_u (
    .clk(clk),
    .rxd(rxd)
  );
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input int tol);
    cmp_count++;
    if (!(g === e || (tol > 0 && (g === e + 1 || g === e - 1)))) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, v, 3'b111};
    // each channel released at the edge its ready is seen; bready held until bvalid
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    {araddr, arvalid, rready} <= {a, 2'b11};
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    {d, r} = {rdata, rresp};
    rready <= 1'b0;
  endtask
  task automatic cal(input logic [3:0] m, input int bitc);
    c = {24'h0, m[3], 3'h0, m[2:0], 1'b1};
    pre = (m[2] && m[1]) ? 32 : (m[2] || m[1]) ? 128 : 512;
    wr(`ABD_OFF_CTRL, c);
    fork
      line_u.send(m[0], bitc);
      begin
        repeat (bitc * 5) @(posedge clk);
        rd(`ABD_OFF_CTRL);
        chk(d & 32'h61, 32'h01, 0);
      end
    join
    rd(`ABD_OFF_CTRL);
    chk(d, (c & 32'h8E) | 32'h60, 0);
    chk({31'h0, irq}, {31'h0, m[3]}, 0);
    rd(`ABD_OFF_DIV_LO);
    c = d;
    rd(`ABD_OFF_DIV_HI);
    chk({16'h0, d[7:0], c[7:0]}, 32'(8 * bitc / pre + 1), 1);
    rd(`ABD_OFF_RXDATA);
    chk(d, 32'h0, 0);
    rd(`ABD_OFF_CTRL);
    chk(d & 32'h40, 32'h0, 0);
    chk({31'h0, irq}, 32'h0, 0);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // run is near 64k cycles; limit at 95k
  initial begin
    #380000;
    err_count++;
    print_verdict();
  end
  initial begin
    {arst_n, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    {awaddr, araddr, wdata} = 40'h0;
    wstrb = 4'hF;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    rd(`ABD_OFF_CTRL);
    chk(d, 32'h20, 0);
    rd(`ABD_OFF_DIV_HI);
    chk(d, 32'h0, 0);
    wr(`ABD_OFF_DIV_LO, 32'hA5);
    chk({30'h0, r}, {30'h0, `ABD_RESP_OKAY}, 0);
    wr(4'h2, 32'h5A);
    chk({30'h0, r}, {30'h0, `ABD_RESP_SLVERR}, 0);
    rd(`ABD_OFF_DIV_LO);
    chk(d, 32'hA5, 0);
    rd(4'h2);
    chk({30'h0, r}, {30'h0, `ABD_RESP_SLVERR}, 0);
    $display("test registers done");
    for (int i = 0; i < 6; i++) begin
      cal(tmode[i], tbit[i]);
      $display("test calibration %0d done", i);
    end
    print_verdict();
  end
endmodule

// file: include/abd_defs.vh
// abd_defs.vh: register map, field positions and counts for the autobaud block
// assumes inclusion by bare name from src/ modules
`ifndef ABD_DEFS_VH
`define ABD_DEFS_VH
// register byte offsets
`define ABD_OFF_CTRL      4'h0
`define ABD_OFF_DIV_LO    4'h4
`define ABD_OFF_DIV_HI    4'h8
`define ABD_OFF_RXDATA    4'hC
`define ABD_ADDR_W        4
// control / status bit positions
`define ABD_CTRL_ENABLE   0
`define ABD_CTRL_WAKE     1
`define ABD_CTRL_WIDE     2
`define ABD_CTRL_HSPD     3
`define ABD_CTRL_OVF      4
`define ABD_CTRL_IDLE     5
`define ABD_CTRL_RXIF     6
`define ABD_CTRL_IRQ_EN   7
`define ABD_CTRL_WMASK    8'h9F
// prescaler terminal counts (ticks of CLK_SYS), then rise, counter and response constants
`define ABD_DIV512        9'h1FF
`define ABD_DIV128        9'h07F
`define ABD_DIV32         9'h01F
`define ABD_RISE_LAST     3'h5
`define ABD_CNT_START     16'h0001
`define ABD_CNT_MAX       16'hFFFF
`define ABD_RESP_OKAY     2'h0
`define ABD_RESP_SLVERR   2'h2
`endif

// file: src/abd_sync.v
// abd_sync.v: two-flop synchroniser with rise/fall detect on the second stage
// assumes the input is a level idling high
`timescale 1ns/100ps
module abd_sync (
  // clock and reset
  input  wire clk,
  input  wire arst_n,
  // line
  input  wire din,
  output reg  dout,
  output wire rise,
  output wire fall
);
  reg meta_q;
  reg last_q;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= 1'b1;
      dout   <= 1'b1;
      last_q <= 1'b1;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
      last_q <= dout;
    end
  end
  // edges only from the second stage on
  assign rise = dout & ~last_q;
  assign fall = ~dout & last_q;
endmodule

// file: src/abd_top.v
// abd_top.v: autobaud measurement of a 0x55 sync character behind AXI4-Lite
// assumes RXD idles high and one clock CLK_SYS; registers one word each
// Operation
// - setting autobaud enable makes the receiver time the 0x55 sync character
// - receive machine idles and delivers nothing while calibration runs
// - counting starts at first rising edge after the start bit
// - counting stops at fifth rising edge, the stop-bit edge
// - on completion keep count, clear enable, set receive interrupt flag
// - software reads receive data to clear the flag and discards the value
// - both divisor bytes form one 16-bit counter during calibration
// - counter clocked at one eighth of the divider base clock
// - clock select: /512, /128 with one bit set, /32 with both
// - counter starts at one; software subtracts one afterwards
// - with wake-on-break set, calibrate the character after the break
// - counter overflow sets overflow and interrupt flags, keeps counting
// - receive idle reads zero during calibration, one at fifth edge
//
// Decided for this implementation: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/100ps
`include "abd_defs.vh"
module abd_top (
  // clock and reset
  input  wire        CLK_SYS,
  input  wire        ARST_N,
  // serial line
  input  wire        RXD,
  // interrupt
  output wire        IRQ,
  // axi4-lite write address
  input  wire [3:0]  S_AXI_AWADDR,
  input  wire        S_AXI_AWVALID,
  output wire        S_AXI_AWREADY,
  // axi4-lite write data
  input  wire [31:0] S_AXI_WDATA,
  input  wire [3:0]  S_AXI_WSTRB,
  input  wire        S_AXI_WVALID,
  output wire        S_AXI_WREADY,
  // axi4-lite write response
  output reg  [1:0]  S_AXI_BRESP,
  output reg         S_AXI_BVALID,
  input  wire        S_AXI_BREADY,
  // axi4-lite read address
  input  wire [3:0]  S_AXI_ARADDR,
  input  wire        S_AXI_ARVALID,
  output wire        S_AXI_ARREADY,
  // axi4-lite read data
  output reg  [31:0] S_AXI_RDATA,
  output reg  [1:0]  S_AXI_RRESP,
  output reg         S_AXI_RVALID,
  input  wire        S_AXI_RREADY
);
  localparam ST_IDLE  = 2'b00;
  localparam ST_BREAK = 2'b01;
  localparam ST_START = 2'b10;
  localparam ST_COUNT = 2'b11;

  // line conditioning
  wire rx_s;
  wire rx_rise;
  wire rx_fall;
  abd_sync u_sync (
    .clk    (CLK_SYS),
    .arst_n (ARST_N),
    .din    (RXD),
    .dout   (rx_s),
    .rise   (rx_rise),
    .fall   (rx_fall)
  );

  // register state
  reg        enable_q;
  reg        wake_q;
  reg        wide_q;
  reg        hspd_q;
  reg        ovf_q;
  reg        idle_q;
  reg        rxif_q;
  reg        irq_en_q;
  reg [15:0] div_q;
  reg [7:0]  rxdata_q;
  reg [1:0]  state_q;
  reg [2:0]  rises_q;
  reg [8:0]  pre_q;

  // bus handshake state
  reg        aw_hold_q;
  reg        w_hold_q;
  reg [3:0]  awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0]  wstrb_q;

  assign S_AXI_AWREADY = ~aw_hold_q & ~S_AXI_BVALID;
  assign S_AXI_WREADY  = ~w_hold_q & ~S_AXI_BVALID;
  assign S_AXI_ARREADY = ~S_AXI_RVALID;

  wire aw_hs = S_AXI_AWVALID & S_AXI_AWREADY;
  wire w_hs  = S_AXI_WVALID & S_AXI_WREADY;
  wire ar_hs = S_AXI_ARVALID & S_AXI_ARREADY;
  wire aw_have = aw_hold_q | aw_hs;
  wire w_have  = w_hold_q | w_hs;
  wire wr_go   = aw_have & w_have;
  wire [3:0]  wr_addr = aw_hold_q ? awaddr_q : S_AXI_AWADDR;
  wire [31:0] wr_data = w_hold_q ? wdata_q : S_AXI_WDATA;
  wire [3:0]  wr_strb = w_hold_q ? wstrb_q : S_AXI_WSTRB;
  wire wr_ok   = (wr_addr == `ABD_OFF_CTRL) | (wr_addr == `ABD_OFF_DIV_LO) |
                 (wr_addr == `ABD_OFF_DIV_HI) | (wr_addr == `ABD_OFF_RXDATA);
  wire wr_ctrl = wr_go & wr_strb[0] & (wr_addr == `ABD_OFF_CTRL);
  wire wr_lo   = wr_go & wr_strb[0] & (wr_addr == `ABD_OFF_DIV_LO);
  wire wr_hi   = wr_go & wr_strb[0] & (wr_addr == `ABD_OFF_DIV_HI);
  wire rd_data = ar_hs & (S_AXI_ARADDR == `ABD_OFF_RXDATA);

  // prescaler: one enable pulse per calibration clock period
  reg [8:0] pre_term;
  always @* begin
    case ({wide_q, hspd_q})
      2'b00:   pre_term = `ABD_DIV512;
      2'b11:   pre_term = `ABD_DIV32;
      default: pre_term = `ABD_DIV128;
    endcase
  end
  wire cal_tick = (pre_q == pre_term);

  // measurement events
  wire counting  = enable_q & (state_q == ST_COUNT);
  wire last_rise = counting & rx_rise & (rises_q == `ABD_RISE_LAST - 3'h1);
  wire cnt_wrap  = counting & cal_tick & (div_q == `ABD_CNT_MAX) & ~last_rise;
  wire done      = last_rise;

  always @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      state_q <= ST_IDLE;
      rises_q <= 3'h0;
      pre_q   <= 9'h000;
    end else begin
      if (counting && !cal_tick)
        pre_q <= pre_q + 9'h001;
      else
        pre_q <= 9'h000;
      case (state_q)
        ST_IDLE: begin
          if (enable_q)
            state_q <= wake_q ? ST_BREAK : ST_START;
        end
        ST_BREAK: begin
          // break ends on its rising edge; the sync that follows is measured
          if (!enable_q)
            state_q <= ST_IDLE;
          else if (rx_rise)
            state_q <= ST_START;
        end
        ST_START: begin
          if (!enable_q)
            state_q <= ST_IDLE;
          else if (rx_fall)
            rises_q <= 3'h0;
          else if (rx_rise && !rx_s) begin
            rises_q <= 3'h0;
          end else if (rx_rise) begin
            state_q <= ST_COUNT;
            rises_q <= 3'h1;
          end
        end
        ST_COUNT: begin
          if (!enable_q || done)
            state_q <= ST_IDLE;
          else if (rx_rise)
            rises_q <= rises_q + 3'h1;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // control, divisor and flags
  always @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      enable_q <= 1'b0;
      wake_q   <= 1'b0;
      wide_q   <= 1'b0;
      hspd_q   <= 1'b0;
      ovf_q    <= 1'b0;
      idle_q   <= 1'b1;
      rxif_q   <= 1'b0;
      irq_en_q <= 1'b0;
      div_q    <= 16'h0000;
      rxdata_q <= 8'h00;
    end else begin
      if (wr_ctrl) begin
        wake_q   <= wr_data[`ABD_CTRL_WAKE];
        wide_q   <= wr_data[`ABD_CTRL_WIDE];
        hspd_q   <= wr_data[`ABD_CTRL_HSPD];
        irq_en_q <= wr_data[`ABD_CTRL_IRQ_EN];
      end
      // hardware clear on completion wins over a software write
      if (done)
        enable_q <= 1'b0;
      else if (wr_ctrl)
        enable_q <= wr_data[`ABD_CTRL_ENABLE];
      // overflow: set wins over software write-one clear
      if (cnt_wrap)
        ovf_q <= 1'b1;
      else if (wr_ctrl && wr_data[`ABD_CTRL_OVF])
        ovf_q <= 1'b0;
      if (done)
        idle_q <= 1'b1;
      else if (enable_q)
        idle_q <= 1'b0;
      // flag set wins over the data read that clears it
      if (done || cnt_wrap)
        rxif_q <= 1'b1;
      else if (rd_data)
        rxif_q <= 1'b0;
      // counter: reload to one on start, full 16 bits always
      if (state_q == ST_START && rx_rise && rx_s && enable_q)
        div_q <= `ABD_CNT_START;
      else if (counting && cal_tick && !last_rise)
        div_q <= div_q + 16'h0001;
      else if (!enable_q && wr_lo)
        div_q[7:0] <= wr_data[7:0];
      else if (!enable_q && wr_hi)
        div_q[15:8] <= wr_data[7:0];
      // no characters assembled while calibrating; read data stays zero
      if (enable_q)
        rxdata_q <= 8'h00;
    end
  end

  assign IRQ = rxif_q & irq_en_q;

  // axi write channel
  always @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      aw_hold_q    <= 1'b0;
      w_hold_q     <= 1'b0;
      awaddr_q     <= 4'h0;
      wdata_q      <= 32'h0000_0000;
      wstrb_q      <= 4'h0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= `ABD_RESP_OKAY;
    end else begin
      if (wr_go) begin
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= wr_ok ? `ABD_RESP_OKAY : `ABD_RESP_SLVERR;
      end else begin
        if (aw_hs) begin
          aw_hold_q <= 1'b1;
          awaddr_q  <= S_AXI_AWADDR;
        end
        if (w_hs) begin
          w_hold_q <= 1'b1;
          wdata_q  <= S_AXI_WDATA;
          wstrb_q  <= S_AXI_WSTRB;
        end
        if (S_AXI_BVALID && S_AXI_BREADY)
          S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // axi read channel
  always @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA  <= 32'h0000_0000;
      S_AXI_RRESP  <= `ABD_RESP_OKAY;
    end else if (ar_hs) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RRESP  <= `ABD_RESP_OKAY;
      case (S_AXI_ARADDR)
        `ABD_OFF_CTRL:   S_AXI_RDATA <= {24'h000000, irq_en_q, rxif_q, idle_q, ovf_q,
                                         hspd_q, wide_q, wake_q, enable_q};
        `ABD_OFF_DIV_LO: S_AXI_RDATA <= {24'h000000, div_q[7:0]};
        `ABD_OFF_DIV_HI: S_AXI_RDATA <= {24'h000000, div_q[15:8]};
        `ABD_OFF_RXDATA: S_AXI_RDATA <= {24'h000000, rxdata_q};
        default: begin
          S_AXI_RDATA <= 32'h0000_0000;
          S_AXI_RRESP <= `ABD_RESP_SLVERR;
        end
      endcase
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end
endmodule
